/* File: core/ext_irq_detect.sv */
// Machine-cycle sampler for one external interrupt input.
// Assumes pin_level is already synchronised to sys_clk.
`timescale 1ns/1ps
`include "pic_defines.svh"

module ext_irq_detect (
    input wire logic sys_clk,
    input wire logic rst_sync_n,
    input wire logic tick,
    input wire logic pin_level,
    output logic fell,
    output logic low
);
    import pic_pkg::*;

    ext_det_s s;
    ext_det_s next_s;

    // ------------------------------------------------------------------
    // Sampling
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.fell = 1'b0;
        if (tick) begin
            next_s.prev = pin_level;
            next_s.fell = s.prev & ~pin_level;
            next_s.low = ~pin_level;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '0;
            s.prev <= `PIN_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign fell = s.fell;
    assign low = s.low;

    edge_on_tick_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s.fell |-> $past(tick) && !$past(pin_level))
        else $error("edge flagged without tick");

endmodule // ext_irq_detect

/* File: core/pic_defines.svh */
// Constants for the prioritised interrupt controller.
// Assumes inclusion by bare name from the package and the design modules.
//
// Functional notes
// - Eleven sources with flag, enable, priority, vector; one global gate.
// - Each external input selects falling-edge or low-level triggering.
// - Edge mode samples once per machine cycle; high then low sets flag.
// - Edge external flag clears on vectoring; level flag is not cleared.
// - Level source holds pin low until serviced; still low means new request.
// - Timer a and b overflow flags clear in hardware on vectoring.
// - Watchdog flag set on time-out; requests if enabled; software clear.
// - Uart, timer c and capture flags are cleared by software only.
// - Two-wire flag set on new status; needs global and own enable.
// - Two-wire clear starts next action; done posts status, sets flag.
// - Any enabled keypad pin press sets keypad flag; software clear only.
// - Brownout flag requests only with select, enable and global gate.
// - Vectors 0003H plus 8 per slot; watchdog slot 10, capture slot 13.
// - Four levels; running service never pre-empted by lower or equal level.
// - Equal-level simultaneous requests resolved by fixed source ranking.
// - Flags sampled, polled and resolved every machine cycle.
// - Call needs no equal/higher active, last cycle, unblocked instruction.
// - Requests are not latched; each poll starts afresh.
// - Call pushes program counter only, then loads the selected vector.
// - Interrupt return pops and ends top level; plain return only pops.
// - Priority is high bit and low bit, 00 lowest to 11 highest.
// - Tie ranking: ext a, brownout, watchdog, timer a, two-wire, ext b, ...
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define N_SRC 11
`define N_LVL 4
`define KEY_W 8
`define DIV_W 8
`define MC_DIV_DEFAULT 12

// ----------------------------------------------------------------------
// Source indices (vector slot order)
// ----------------------------------------------------------------------
`define SRC_EXT_A 0
`define SRC_TMR_A 1
`define SRC_EXT_B 2
`define SRC_TMR_B 3
`define SRC_UART 4
`define SRC_BROWN 5
`define SRC_TWO 6
`define SRC_KEY 7
`define SRC_TMR_C 8
`define SRC_WDOG 9
`define SRC_CAPT 10

// ----------------------------------------------------------------------
// Vectors
// ----------------------------------------------------------------------
`define VEC_BASE 16'h0003
`define VEC_LOW_BITS 3'h3
`define SLOT_WDOG 4'hA
`define SLOT_CAPT 4'hD
`define VEC_WDOG 16'h0053
`define VEC_CAPT 16'h006B

// ----------------------------------------------------------------------
// Reset levels
// ----------------------------------------------------------------------
`define PIN_IDLE 1'b1
`define TRIG_EDGE 1'b1

`endif

/* File: core/pic_pkg.sv */
// Types shared by the interrupt controller modules.
// Assumes pic_defines.svh is on the include path.
`include "pic_defines.svh"

package pic_pkg;

    typedef struct packed {
        logic [15:0] vector;
        logic [3:0] source;
        logic [1:0] level;
    } call_s;

    typedef struct packed {
        logic begin_cond;
        logic end_cond;
        logic ack;
    } twowire_cmd_s;

    typedef struct packed {
        logic prev;
        logic fell;
        logic low;
    } ext_det_s;

    typedef struct packed {
        logic [`DIV_W-1:0] div_cnt;
        logic tick;
        logic [1:0] ext_meta;
        logic [1:0] ext_pin;
        logic [`KEY_W-1:0] key_meta;
        logic [`KEY_W-1:0] key_pin;
        logic [`KEY_W-1:0] key_prev;
        logic bo_meta;
        logic bo_pin;
        logic [`N_SRC-1:0] flags;
        logic uart_tx;
        logic [`N_LVL-1:0] in_service;
        logic [7:0] tw_status;
        logic tw_action;
        twowire_cmd_s tw_cmd;
        call_s call;
        logic call_valid;
        logic stack_pop;
    } pic_state_s;

endpackage

/* File: core/priority_interrupt_controller.sv */
// Four-level prioritised interrupt controller, eleven sources.
// Assumes core status inputs and peripheral event pulses are on sys_clk;
// pins (external, keypad, brownout) are asynchronous and synchronised here.
`timescale 1ns/1ps
`include "pic_defines.svh"

module priority_interrupt_controller #(
    parameter int MC_DIV = `MC_DIV_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic ext_a_trigger_type,
    input wire logic ext_b_trigger_type,
    input wire logic [`KEY_W-1:0] keypad_pins,
    input wire logic [`KEY_W-1:0] keypad_enable,
    input wire logic brownout_detect,
    input wire logic timer_a_overflow,
    input wire logic timer_b_overflow,
    input wire logic timer_c_event,
    input wire logic watchdog_timeout,
    input wire logic uart_rx_event,
    input wire logic uart_tx_event,
    input wire logic capture_event,
    input wire logic twowire_done,
    input wire logic [7:0] twowire_status_in,
    input wire logic begin_condition_req,
    input wire logic end_condition_req,
    input wire logic ack_return_ctrl,
    input wire logic [`N_SRC-1:0] flag_clear,
    input wire logic uart_tx_clear,
    input wire logic global_irq_gate,
    input wire logic [`N_SRC-1:0] src_enable,
    input wire logic brownout_irq_select,
    input wire logic [`N_SRC-1:0] priority_high_bits,
    input wire logic [`N_SRC-1:0] priority_low_bits,
    input wire logic core_last_cycle,
    input wire logic core_instr_irq_return,
    input wire logic core_instr_plain_return,
    input wire logic core_instr_blocking,
    output pic_pkg::call_s call_info,
    output logic call_push_pc,
    output logic stack_pop,
    output logic [`N_SRC-1:0] irq_flags,
    output logic uart_tx_flag,
    output logic [`N_LVL-1:0] in_service,
    output logic [7:0] twowire_status_code_reg,
    output logic twowire_action,
    output pic_pkg::twowire_cmd_s twowire_cmd
);
    import pic_pkg::*;

    if (MC_DIV < 2 || MC_DIV > (1 << `DIV_W)) begin : g_bad_div
        $error("MC_DIV out of range");
    end

    pic_state_s s;
    pic_state_s next_s;
    logic rst_sync_n;
    logic fell_a;
    logic fell_b;
    logic low_a;
    logic low_b;

    // ------------------------------------------------------------------
    // Ranking and slot tables
    // ------------------------------------------------------------------
    // tie ranking, rank 0 highest
    function automatic logic [3:0] rank_src(input int r);
        case (r)
            0: rank_src = 4'(`SRC_EXT_A);
            1: rank_src = 4'(`SRC_BROWN);
            2: rank_src = 4'(`SRC_WDOG);
            3: rank_src = 4'(`SRC_TMR_A);
            4: rank_src = 4'(`SRC_TWO);
            5: rank_src = 4'(`SRC_EXT_B);
            6: rank_src = 4'(`SRC_KEY);
            7: rank_src = 4'(`SRC_TMR_B);
            8: rank_src = 4'(`SRC_UART);
            9: rank_src = 4'(`SRC_TMR_C);
            default: rank_src = 4'(`SRC_CAPT);
        endcase
    endfunction

    function automatic logic [3:0] slot_of(input logic [3:0] src);
        case (src)
            4'(`SRC_WDOG): slot_of = `SLOT_WDOG;
            4'(`SRC_CAPT): slot_of = `SLOT_CAPT;
            default: slot_of = src;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_pipe;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe[1];

    // ------------------------------------------------------------------
    // External input samplers
    // ------------------------------------------------------------------
    ext_irq_detect u_det_a (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .tick(s.tick),
        .pin_level(s.ext_pin[0]),
        .fell(fell_a),
        .low(low_a)
    );

    ext_irq_detect u_det_b (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .tick(s.tick),
        .pin_level(s.ext_pin[1]),
        .fell(fell_b),
        .low(low_b)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [`N_SRC-1:0] setv;
        logic [`N_SRC-1:0] hwclr;
        logic [`N_SRC-1:0] req;
        logic [`KEY_W-1:0] kfall;
        logic [3:0] src;
        logic [1:0] lvl;
        logic [3:0] best_src;
        logic [1:0] best_lvl;
        logic best_ok;
        logic [1:0] act_lvl;
        logic act_ok;
        setv = '0;
        hwclr = '0;
        req = '0;
        kfall = '0;
        src = '0;
        lvl = '0;
        best_src = '0;
        best_lvl = '0;
        best_ok = 1'b0;
        act_lvl = '0;
        act_ok = 1'b0;
        next_s = s;
        next_s.tick = 1'b0;
        next_s.call_valid = 1'b0;
        next_s.stack_pop = 1'b0;
        next_s.tw_action = 1'b0;

        // Machine-cycle divider
        if (s.div_cnt == `DIV_W'(MC_DIV - 1)) begin
            next_s.div_cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.div_cnt = s.div_cnt + `DIV_W'(1);
        end

        // Pin synchronisers
        next_s.ext_meta = {ext_irq_pin_b, ext_irq_pin_a};
        next_s.ext_pin = s.ext_meta;
        next_s.key_meta = keypad_pins;
        next_s.key_pin = s.key_meta;
        next_s.key_prev = s.key_pin;
        next_s.bo_meta = brownout_detect;
        next_s.bo_pin = s.bo_meta;

        // flag, own enable and global gate together
        req = s.flags & src_enable & {`N_SRC{global_irq_gate}};
        req[`SRC_UART] = (s.flags[`SRC_UART] | s.uart_tx)
            & src_enable[`SRC_UART] & global_irq_gate;
        req[`SRC_BROWN] = req[`SRC_BROWN] & brownout_irq_select;

        for (int r = `N_SRC - 1; r >= 0; r--) begin
            src = rank_src(r);
            lvl = {priority_high_bits[src], priority_low_bits[src]};
            if (req[src] && (!best_ok || lvl >= best_lvl)) begin
                best_ok = 1'b1;
                best_src = src;
                best_lvl = lvl;
            end
        end

        for (int l = 0; l < `N_LVL; l++) begin
            if (s.in_service[l]) begin
                act_ok = 1'b1;
                act_lvl = 2'(l);
            end
        end

        if (s.tick && core_last_cycle) begin
            if (core_instr_irq_return) begin
                next_s.stack_pop = 1'b1;
                if (act_ok) begin
                    next_s.in_service[act_lvl] = 1'b0;
                end
            end else if (core_instr_plain_return) begin
                next_s.stack_pop = 1'b1;
            end else if (!core_instr_blocking && best_ok
                         && (!act_ok || best_lvl > act_lvl)) begin
                next_s.call_valid = 1'b1;
                next_s.call.source = best_src;
                next_s.call.level = best_lvl;
                next_s.call.vector = `VEC_BASE
                    + {9'h000, slot_of(best_src), 3'h0};
                next_s.in_service[best_lvl] = 1'b1;
                // edge external flags clear on entry
                // timer a and b flags clear on entry
                case (best_src)
                    4'(`SRC_EXT_A): hwclr[`SRC_EXT_A] = 1'b1;
                    4'(`SRC_EXT_B): hwclr[`SRC_EXT_B] = 1'b1;
                    4'(`SRC_TMR_A): hwclr[`SRC_TMR_A] = 1'b1;
                    4'(`SRC_TMR_B): hwclr[`SRC_TMR_B] = 1'b1;
                    default: hwclr = '0;
                endcase
            end
        end

        // Event sources
        setv[`SRC_EXT_A] = fell_a;
        setv[`SRC_EXT_B] = fell_b;
        setv[`SRC_TMR_A] = timer_a_overflow;
        setv[`SRC_TMR_B] = timer_b_overflow;
        setv[`SRC_TMR_C] = timer_c_event;
        setv[`SRC_WDOG] = watchdog_timeout;
        setv[`SRC_UART] = uart_rx_event;
        setv[`SRC_CAPT] = capture_event;
        // new status code sets two-wire flag
        setv[`SRC_TWO] = twowire_done;
        kfall = s.key_prev & ~s.key_pin & keypad_enable;
        setv[`SRC_KEY] = |kfall;
        setv[`SRC_BROWN] = s.bo_pin;

        // software clears, set wins over clear
        next_s.flags = (s.flags & ~(flag_clear | hwclr)) | setv;
        next_s.uart_tx = (s.uart_tx & ~uart_tx_clear) | uart_tx_event;

        // level mode follows the sampled pin
        if (ext_a_trigger_type != `TRIG_EDGE) begin
            next_s.flags[`SRC_EXT_A] = low_a;
        end
        if (ext_b_trigger_type != `TRIG_EDGE) begin
            next_s.flags[`SRC_EXT_B] = low_b;
        end

        // clearing the flag releases the next action
        if (flag_clear[`SRC_TWO] && s.flags[`SRC_TWO]) begin
            next_s.tw_action = 1'b1;
            next_s.tw_cmd = {begin_condition_req, end_condition_req,
                             ack_return_ctrl};
        end
        if (twowire_done) begin
            next_s.tw_status = twowire_status_in;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '0;
            s.ext_meta <= {2{`PIN_IDLE}};
            s.ext_pin <= {2{`PIN_IDLE}};
            s.key_meta <= {`KEY_W{`PIN_IDLE}};
            s.key_pin <= {`KEY_W{`PIN_IDLE}};
            s.key_prev <= {`KEY_W{`PIN_IDLE}};
        end else begin
            s <= next_s;
        end
    end

    // push program counter only, load vector
    assign call_info = s.call;
    assign call_push_pc = s.call_valid;
    assign stack_pop = s.stack_pop;
    assign irq_flags = s.flags;
    assign uart_tx_flag = s.uart_tx;
    assign in_service = s.in_service;
    assign twowire_status_code_reg = s.tw_status;
    assign twowire_action = s.tw_action;
    assign twowire_cmd = s.tw_cmd;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    call_last_cycle_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s.call_valid |-> $past(s.tick) && $past(core_last_cycle))
        else $error("call outside last cycle");
    call_instr_ok_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s.call_valid |-> !$past(core_instr_irq_return)
        && !$past(core_instr_plain_return) && !$past(core_instr_blocking))
        else $error("call on blocked instruction");
    call_gate_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s.call_valid |-> $past(global_irq_gate))
        else $error("call with gate closed");
    timer_hw_clear_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s.call_valid && s.call.source == 4'(`SRC_TMR_A)
        && !$past(timer_a_overflow) |-> !s.flags[`SRC_TMR_A])
        else $error("timer flag kept after call");
    wdog_sw_clear_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        $fell(s.flags[`SRC_WDOG]) |-> $past(flag_clear[`SRC_WDOG])
        && !$past(watchdog_timeout))
        else $error("watchdog flag lost");
    uart_keep_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        $past(s.flags[`SRC_UART]) && !$past(flag_clear[`SRC_UART])
        |-> s.flags[`SRC_UART])
        else $error("uart flag cleared by hardware");
    no_preempt_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s.call_valid |-> ($past(s.in_service) >> s.call.level) == 4'h0)
        else $error("pre-empted by equal or lower level");
    vector_slot_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s.call_valid |-> s.call.vector[2:0] == `VEC_LOW_BITS
        && (s.call.source != 4'(`SRC_WDOG) || s.call.vector == `VEC_WDOG)
        && (s.call.source != 4'(`SRC_CAPT) || s.call.vector == `VEC_CAPT))
        else $error("bad vector");
    return_release_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s.tick && core_last_cycle && core_instr_irq_return
        && s.in_service != 4'h0 |=> s.stack_pop
        && $countones(s.in_service) == $countones($past(s.in_service)) - 1)
        else $error("return did not end service");
    twowire_next_a: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s.tw_action |-> $past(s.flags[`SRC_TWO])
        && $past(flag_clear[`SRC_TWO]))
        else $error("two-wire action without clear");

endmodule // priority_interrupt_controller

/* File: testbench/core_model.sv */
// Processor core stand-in: pc, stack and return requests on command.
// Assumes call and pop pulses from the controller on sys_clk.
`timescale 1ns/1ps

module core_model (
    input wire logic sys_clk,
    input wire logic call_push_pc,
    input wire logic stack_pop,
    input wire logic [15:0] vector,
    input wire logic [1:0] ret_cmd,
    input wire logic blk_cmd,
    output logic core_last_cycle,
    output logic core_instr_irq_return,
    output logic core_instr_plain_return,
    output logic core_instr_blocking,
    output logic [15:0] pc
);
    logic [15:0] stack [$];

    initial begin
        pc = 16'h0100;
        core_instr_irq_return = 1'b0;
        core_instr_plain_return = 1'b0;
    end
    // ------------------------------------------------------------
    // One-cycle instructions, returns held until popped
    // ------------------------------------------------------------
    // every cycle is a last cycle
    assign core_last_cycle = 1'b1;
    assign core_instr_blocking = blk_cmd;
    always @(posedge sys_clk) begin
        if (call_push_pc) begin
            stack.push_back(pc);
            pc <= vector;
        end
        if (stack_pop) begin
            if (stack.size() > 0)
                pc <= stack.pop_back();
            core_instr_irq_return <= 1'b0;
            core_instr_plain_return <= 1'b0;
        end else if (ret_cmd[0]) begin
            core_instr_irq_return <= 1'b1;
        end else if (ret_cmd[1]) begin
            core_instr_plain_return <= 1'b1;
        end
    end
endmodule // core_model

/* File: testbench/test_priority_interrupt_controller.sv */
// Bench for the interrupt controller: call and return sequences.
// Assumes core_model stands for the core; MC_DIV set to 2.
`timescale 1ns/1ps
`include "pic_defines.svh"

module test_priority_interrupt_controller;
    import pic_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pa = 1'b1;
    logic ta = 1'b1;
    logic bo = 1'b0;
    logic bsel = 1'b0;
    logic gate = 1'b0;
    logic twd = 1'b0;
    logic blk = 1'b0;
    logic [2:0] twc = 3'h0;
    logic [1:0] ret = 2'h0;
    logic [7:0] keys = 8'hFF;
    logic [7:0] ken = 8'h00;
    logic [7:0] tws = 8'h00;
    logic [6:0] ev = 7'h00;
    logic [10:0] fclr = 11'h000;
    logic [10:0] en = 11'h000;
    logic [10:0] phi = 11'h000;
    logic [10:0] plo = 11'h000;
    logic lc, irt, prt, blkc, push, pop, act, utx;
    logic [15:0] pc;
    logic [10:0] flags;
    logic [3:0] insv;
    logic [7:0] stat;
    call_s ci;
    twowire_cmd_s cmd;
    int mismatches = 0;
    int num_checks = 0;

    priority_interrupt_controller #(.MC_DIV(2)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n),
        .ext_irq_pin_a(pa), .ext_irq_pin_b(pa),
        .ext_a_trigger_type(ta), .ext_b_trigger_type(ta),
        .keypad_pins(keys), .keypad_enable(ken), .brownout_detect(bo),
        .timer_a_overflow(ev[0]), .timer_b_overflow(ev[1]),
        .timer_c_event(ev[2]), .watchdog_timeout(ev[3]),
        .uart_rx_event(ev[4]), .uart_tx_event(ev[5]),
        .capture_event(ev[6]), .twowire_done(twd),
        .twowire_status_in(tws), .begin_condition_req(twc[2]),
        .end_condition_req(twc[1]), .ack_return_ctrl(twc[0]),
        .flag_clear(fclr), .uart_tx_clear(fclr[4]),
        .global_irq_gate(gate), .src_enable(en),
        .brownout_irq_select(bsel), .priority_high_bits(phi),
        .priority_low_bits(plo), .core_last_cycle(lc),
        .core_instr_irq_return(irt), .core_instr_plain_return(prt),
        .core_instr_blocking(blkc), .call_info(ci),
        .call_push_pc(push), .stack_pop(pop), .irq_flags(flags),
        .uart_tx_flag(utx), .in_service(insv),
        .twowire_status_code_reg(stat), .twowire_action(act),
        .twowire_cmd(cmd)
    );
    core_model u_core (
        .sys_clk(sys_clk), .call_push_pc(push), .stack_pop(pop),
        .vector(ci.vector), .ret_cmd(ret), .blk_cmd(blk),
        .core_last_cycle(lc), .core_instr_irq_return(irt),
        .core_instr_plain_return(prt), .core_instr_blocking(blkc),
        .pc(pc)
    );

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(input logic [6:0] m);
        @(posedge sys_clk) ev <= m;
        @(posedge sys_clk) ev <= 7'h00;
    endtask
    task automatic clr(input logic [10:0] m);
        @(posedge sys_clk) fclr <= m;
        @(posedge sys_clk) fclr <= 11'h000;
    endtask
    task automatic none(input int n);
        repeat (n) begin
            tick(1);
            check("no call", push, 16'h0000);
        end
    endtask
    task automatic expect_call(input logic [15:0] vec,
            input logic [3:0] src);
        int i;
        i = 0;
        while (push !== 1'b1 && i < 40) begin
            tick(1);
            i++;
        end
        check("call", push, 16'h0001);
        check("vector", ci.vector, vec);
        check("source", ci.source, src);
    endtask
    task automatic do_ret(input logic [1:0] k);
        int i;
        i = 0;
        @(posedge sys_clk) ret <= k;
        @(posedge sys_clk) ret <= 2'h0;
        while (pop !== 1'b1 && i < 20) begin
            tick(1);
            i++;
        end
        check("pop", pop, 16'h0001);
    endtask
    task automatic summarize();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #20000;
        mismatches++;
        summarize();
    end
    initial begin
        tick(4);
        @(posedge sys_clk) rst_n <= 1'b1;
        tick(6);
        check("flags", flags, 16'h0000);
        check("in service", insv, 16'h0000);
        $display("Test reset done");
        @(posedge sys_clk) begin
            en <= 11'h32B;
            phi <= 11'h022;
            plo <= 11'h320;
        end
        pulse(7'h01);
        tick(4);
        check("timer a flag", flags[1], 16'h0001);
        none(6);
        @(posedge sys_clk) gate <= 1'b1;
        expect_call(16'h000B, 4'h1);
        check("call level", ci.level, 16'h0002);
        tick(1);
        check("timer a clr", flags[1], 16'h0000);
        check("level two", insv, 16'h0004);
        check("pc", pc, 16'h000B);
        pulse(7'h0C);
        none(8);
        do_ret(2'h2);
        tick(1);
        check("plain keeps", insv, 16'h0004);
        check("pc back", pc, 16'h0100);
        do_ret(2'h1);
        expect_call(16'h0053, 4'h9);
        tick(1);
        check("wdog kept", flags[9], 16'h0001);
        clr(11'h200);
        none(4);
        do_ret(2'h1);
        expect_call(16'h0043, 4'h8);
        tick(1);
        check("timer c kept", flags[8], 16'h0001);
        clr(11'h100);
        do_ret(2'h1);
        tick(2);
        check("idle", insv, 16'h0000);
        $display("Test priority done");
        @(posedge sys_clk) blk <= 1'b1;
        pulse(7'h02);
        none(6);
        @(posedge sys_clk) blk <= 1'b0;
        expect_call(16'h001B, 4'h3);
        tick(1);
        check("timer b clr", flags[3], 16'h0000);
        do_ret(2'h1);
        $display("Test blocking done");
        @(posedge sys_clk) pa <= 1'b0;
        expect_call(16'h0003, 4'h0);
        tick(1);
        check("edge clr", flags[0], 16'h0000);
        check("ext b edge", flags[2], 16'h0001);
        @(posedge sys_clk) pa <= 1'b1;
        do_ret(2'h1);
        @(posedge sys_clk) begin
            ta <= 1'b0;
            blk <= 1'b1;
            pa <= 1'b0;
        end
        tick(6);
        @(posedge sys_clk) pa <= 1'b1;
        tick(6);
        @(posedge sys_clk) blk <= 1'b0;
        none(6);
        @(posedge sys_clk) pa <= 1'b0;
        expect_call(16'h0003, 4'h0);
        tick(1);
        check("level kept", flags[0], 16'h0001);
        check("ext b level", flags[2], 16'h0001);
        @(posedge sys_clk) pa <= 1'b1;
        tick(6);
        do_ret(2'h1);
        $display("Test external done");
        @(posedge sys_clk) bo <= 1'b1;
        tick(6);
        check("brownout flag", flags[5], 16'h0001);
        none(4);
        @(posedge sys_clk) bsel <= 1'b1;
        expect_call(16'h002B, 4'h5);
        @(posedge sys_clk) bo <= 1'b0;
        tick(4);
        clr(11'h020);
        do_ret(2'h1);
        $display("Test brownout done");
        @(posedge sys_clk) begin
            gate <= 1'b0;
            ken <= 8'h04;
            keys <= 8'hFB;
            twd <= 1'b1;
            tws <= 8'h08;
            twc <= 3'h5;
        end
        @(posedge sys_clk) twd <= 1'b0;
        pulse(7'h70);
        tick(6);
        check("keypad", flags[7], 16'h0001);
        check("uart", {flags[4], utx}, 16'h0003);
        check("capture", flags[10], 16'h0001);
        check("status", stat, 16'h0008);
        check("tw flag", flags[6], 16'h0001);
        clr(11'h040);
        #1;
        check("tw action", act, 16'h0001);
        check("tw cmd", cmd, 16'h0005);
        clr(11'h010);
        tick(1);
        check("uart clr", {flags[4], utx}, 16'h0000);
        $display("Test flags done");
        summarize();
    end
endmodule // test_priority_interrupt_controller
